// ---- core/lpc_phy.sv ----
// lin physical-layer control, status and wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "lpc_cfg.svh"

module lpc_phy
  import lpc_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // wishbone slave
  input  wire lpc_wb_req_t i_wb,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  // transmit path
  input  wire logic        i_txd,
  output logic             o_bus_dominant,
  output lpc_slope_t       o_slope,
  output logic             o_phy_enable,
  // receive path
  input  wire logic        i_bus_rx,
  output logic             o_rxd,
  // supervision
  input  wire logic        i_overtemp,
  input  wire logic        i_supply_undervolt,
  input  wire logic        i_low_power,
  output logic             o_irq,
  output logic             o_wake_event
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  lpc_state_t s;
  lpc_state_t next_s;

  logic       wb_hit;
  logic       rd_ctrl;
  logic       wr_ctrl;
  logic       wr_wake;
  logic       ot_onset;
  logic       drive_req;
  logic       tx_allow;
  logic [7:0] ctrl_rd;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // ack is one cycle; the ~s.ack term keeps a held request from being taken twice
  assign wb_hit  = i_wb.cyc & i_wb.stb & ~s.ack;
  assign rd_ctrl = wb_hit & ~i_wb.we & (i_wb.adr == `LPC_OFF_CTRL);
  assign wr_ctrl = wb_hit & i_wb.we & i_wb.sel[0] & (i_wb.adr == `LPC_OFF_CTRL);
  assign wr_wake = wb_hit & i_wb.we & i_wb.sel[0] & (i_wb.adr == `LPC_OFF_WAKE);

  assign ot_onset  = i_overtemp & ~s.ot;
  assign drive_req = s.ctrl.tx_bit | ~i_txd;

  assign ctrl_rd = {s.ctrl.ot_ie, s.ot, s.rx, s.ctrl.tx_bit,
                    s.ctrl.undervolt_shutdown_disable, s.ctrl.en, s.ctrl.sr};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s            = s;
    next_s.ack        = 1'b0;
    next_s.wake_pulse = 1'b0;
    tx_allow          = 1'b0;

    // register access; unmapped addresses ack with zero data
    if (wb_hit) begin
      next_s.ack = 1'b1;
      next_s.dat = `LPC_DAT_ZERO;
      if (!i_wb.we) begin
        case (i_wb.adr)
          `LPC_OFF_CTRL: next_s.dat[7:0] = ctrl_rd;
          `LPC_OFF_WAKE: next_s.dat[`LPC_B_WAKE] = s.wake_src;
          default: next_s.dat = `LPC_DAT_ZERO;
        endcase
      end
    end
    if (wr_ctrl) begin
      next_s.ctrl.ot_ie  = i_wb.dat[`LPC_B_OT_IE];
      next_s.ctrl.tx_bit = i_wb.dat[`LPC_B_TX];
      next_s.ctrl.undervolt_shutdown_disable   = i_wb.dat[`LPC_B_UNDERVOLT_SHUTDOWN_DISABLE];
      next_s.ctrl.en     = i_wb.dat[`LPC_B_EN];
      next_s.ctrl.sr     = i_wb.dat[`LPC_B_SR_HI:`LPC_B_SR_LO];
    end

    // slope decode
    case (s.ctrl.sr)
      `LPC_SR_SLOW: next_s.slope = LPC_SLOPE_SLOW;
      `LPC_SR_FAST: next_s.slope = LPC_SLOPE_FAST;
      default:      next_s.slope = LPC_SLOPE_NORMAL;
    endcase

    // overtemperature status and interrupt; a fresh onset wins over the read clear
    next_s.ot = i_overtemp;
    if (rd_ctrl) begin
      next_s.irq = 1'b0;
    end
    if (ot_onset & s.ctrl.ot_ie) begin
      next_s.irq = 1'b1;
    end

    // transmitter shutdown on overtemperature
    case (s.tx_state)
      LPC_TX_ON: begin
        if (i_overtemp) begin
          next_s.tx_state = LPC_TX_OT_OFF;
        end
      end
      LPC_TX_OT_OFF: begin
        if (!i_overtemp && i_txd) begin
          next_s.tx_state = LPC_TX_ON;
        end
      end
      default: next_s.tx_state = LPC_TX_ON;
    endcase

    // undervoltage hold: only ever engages or releases while transmit is recessive,
    // so a dominant bit in flight is never cut short
    if (i_supply_undervolt && !s.ctrl.undervolt_shutdown_disable) begin
      if (!drive_req) begin
        next_s.uv_block = 1'b1;
      end
    end else if (!drive_req) begin
      next_s.uv_block = 1'b0;
    end

    // driver output
    tx_allow = s.ctrl.en & (s.tx_state == LPC_TX_ON) & ~i_overtemp
               & ~i_low_power & ~next_s.uv_block;
    next_s.drive_dom = tx_allow & drive_req;

    // receiver and wake detection; the receiver runs in every mode
    next_s.rx = i_bus_rx;
    if (wr_wake && i_wb.dat[`LPC_B_WAKE]) begin
      next_s.wake_src = 1'b0;
    end
    if (i_low_power) begin
      if (!s.rx && i_bus_rx) begin
        if (s.cnt >= `LPC_CNT_W'(`LPC_WAKE_CYC)) begin
          next_s.wake_pulse = 1'b1;
          next_s.wake_src   = 1'b1;
        end
        next_s.cnt = '0;
      end else if (!s.rx) begin
        // saturate so an endless dominant level cannot wrap past the filter
        if (s.cnt < `LPC_CNT_W'(`LPC_WAKE_CYC)) begin
          next_s.cnt = s.cnt + `LPC_CNT_W'(1);
        end
      end else begin
        next_s.cnt = '0;
      end
    end else begin
      next_s.cnt = '0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s.ack        <= 1'b0;
      s.dat        <= `LPC_DAT_ZERO;
      s.ctrl       <= `LPC_CTRL_RST;
      s.slope      <= LPC_SLOPE_NORMAL;
      s.tx_state   <= LPC_TX_ON;
      s.ot         <= 1'b0;
      s.irq        <= 1'b0;
      s.uv_block   <= 1'b0;
      s.rx         <= 1'b1;
      s.cnt        <= '0;
      s.wake_src   <= 1'b0;
      s.wake_pulse <= 1'b0;
      s.drive_dom  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_wb_ack       = s.ack;
  assign o_wb_dat       = s.dat;
  assign o_bus_dominant = s.drive_dom;
  assign o_slope        = s.slope;
  assign o_phy_enable   = s.ctrl.en;
  assign o_rxd          = s.rx;
  assign o_irq          = s.irq;
  assign o_wake_event   = s.wake_pulse;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_slope_slow;
    (s.ctrl.sr == `LPC_SR_SLOW) |=> (o_slope == LPC_SLOPE_SLOW);
  endproperty
  a_slope_slow: assert property (p_slope_slow) else $error("slow slope not selected");

  property p_slope_norm;
    (s.ctrl.sr != `LPC_SR_SLOW && s.ctrl.sr != `LPC_SR_FAST) |=> (o_slope == LPC_SLOPE_NORMAL);
  endproperty
  a_slope_norm: assert property (p_slope_norm) else $error("normal slope not selected");

  property p_ot_off;
    i_overtemp |=> (!o_bus_dominant && s.ot && s.tx_state == LPC_TX_OT_OFF);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("driver active in overtemperature");

  property p_irq_set;
    (ot_onset && s.ctrl.ot_ie) |=> o_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("overtemp onset lost");

  property p_irq_clr;
    (rd_ctrl && !ot_onset) |=> (!o_irq ##1 o_wb_dat[`LPC_B_OT_PRES] == $past(s.ot, 2));
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("read did not clear flag");

  property p_no_refire;
    (!o_irq && s.ot && i_overtemp) |=> !o_irq;
  endproperty
  a_no_refire: assert property (p_no_refire) else $error("interrupt without fresh onset");

  property p_reenable;
    (s.tx_state == LPC_TX_OT_OFF && (i_overtemp || !i_txd)) |=> s.tx_state == LPC_TX_OT_OFF;
  endproperty
  a_reenable: assert property (p_reenable) else $error("early driver re-enable");

  property p_low_power;
    i_low_power |=> !o_bus_dominant;
  endproperty
  a_low_power: assert property (p_low_power) else $error("driver on in low power");

  property p_wake;
    (i_low_power && i_bus_rx && !s.rx && s.cnt >= `LPC_CNT_W'(`LPC_WAKE_CYC))
      |=> (o_wake_event && s.wake_src) ##1 !o_wake_event;
  endproperty
  a_wake: assert property (p_wake) else $error("wake event missed");

  property p_wake_short;
    (s.cnt < `LPC_CNT_W'(`LPC_WAKE_CYC)) |=> !o_wake_event;
  endproperty
  a_wake_short: assert property (p_wake_short) else $error("wake on short dominant");

  property p_uv_hold;
    (i_supply_undervolt && !s.ctrl.undervolt_shutdown_disable && !drive_req) |=> (!o_bus_dominant && s.uv_block);
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("undervoltage hold missing");

  property p_uv_release;
    (s.uv_block && !i_supply_undervolt && !drive_req) |=> !s.uv_block;
  endproperty
  a_uv_release: assert property (p_uv_release) else $error("undervoltage release missing");

  property p_undervolt_shutdown_disable;
    (s.ctrl.undervolt_shutdown_disable && !s.uv_block) |=> !s.uv_block;
  endproperty
  a_undervolt_shutdown_disable: assert property (p_undervolt_shutdown_disable) else $error("hold engaged with shutdown disabled");

  property p_rx_read;
    rd_ctrl |=> (o_wb_ack && o_wb_dat[`LPC_B_RX] == $past(s.rx));
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receiver bit wrong");

  property p_tx_force;
    (s.ctrl.tx_bit && s.ctrl.en && s.tx_state == LPC_TX_ON && !i_overtemp
     && !i_low_power && !s.uv_block) |=> o_bus_dominant;
  endproperty
  a_tx_force: assert property (p_tx_force) else $error("forced dominant missing");

  property p_disabled;
    !s.ctrl.en |=> !o_bus_dominant;
  endproperty
  a_disabled: assert property (p_disabled) else $error("driver on while disabled");

  property p_txd_low;
    (!i_txd && s.ctrl.en && s.tx_state == LPC_TX_ON && !i_overtemp
     && !i_low_power && !s.uv_block) |=> o_bus_dominant;
  endproperty
  a_txd_low: assert property (p_txd_low) else $error("transmit low not driven");

  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_slope_fast;
    (s.ctrl.sr == `LPC_SR_FAST) |=> (o_slope == LPC_SLOPE_FAST);
  endproperty
  a_slope_fast: assert property (p_slope_fast) else $error("fast slope not selected");

  property p_irq_hold;
    (o_irq && !rd_ctrl) |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag lost without read");

  property p_irq_cause;
    (!o_irq && !(ot_onset && s.ctrl.ot_ie)) |=> !o_irq;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without onset");

  property p_wake_lp;
    !i_low_power |=> !o_wake_event;
  endproperty
  a_wake_lp: assert property (p_wake_lp) else $error("wake outside low power");

  property p_wake_keep;
    (s.wake_src && !wr_wake) |=> s.wake_src;
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake flag lost");

  property p_rxd_follow;
    1'b1 |=> (o_rxd == $past(i_bus_rx));
  endproperty
  a_rxd_follow: assert property (p_rxd_follow) else $error("receiver level not tracked");

  property p_uv_wait;
    (i_supply_undervolt && !s.ctrl.undervolt_shutdown_disable && drive_req && !s.uv_block) |=> !s.uv_block;
  endproperty
  a_uv_wait: assert property (p_uv_wait) else $error("hold cut a dominant bit");

  property p_uv_stay;
    (s.uv_block && drive_req) |=> s.uv_block;
  endproperty
  a_uv_stay: assert property (p_uv_stay) else $error("hold left during dominant");

  property p_ack_taken;
    !wb_hit |=> !o_wb_ack;
  endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("ack without request");

  c_irq:   cover property (ot_onset && s.ctrl.ot_ie ##1 o_irq);
  c_wake:  cover property (o_wake_event);
  c_uv:    cover property (s.uv_block && i_supply_undervolt);
  c_reen:  cover property (s.tx_state == LPC_TX_OT_OFF ##1 s.tx_state == LPC_TX_ON);
  c_fast:  cover property (o_slope == LPC_SLOPE_FAST);

endmodule : lpc_phy

// ---- pkg/lpc_cfg.svh ----
// constants of the lin physical-layer control block
`ifndef LPC_CFG_SVH
`define LPC_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LPC_OFF_CTRL     8'h18
`define LPC_OFF_WAKE     8'h1c
`define LPC_CTRL_RST     6'h00
`define LPC_DAT_ZERO     32'h0000_0000

// ----------------------------------------
// control/status fields
// ----------------------------------------
`define LPC_B_OT_IE      7
`define LPC_B_OT_PRES    6
`define LPC_B_RX         5
`define LPC_B_TX         4
`define LPC_B_UNDERVOLT_SHUTDOWN_DISABLE       3
`define LPC_B_EN         2
`define LPC_B_SR_HI      1
`define LPC_B_SR_LO      0
`define LPC_B_WAKE       0
`define LPC_SR_SLOW      2'h1
`define LPC_SR_FAST      2'h2
`define LPC_SR_RST       2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define LPC_CLK_MHZ      10
`define LPC_WAKE_FILT_US 100
`define LPC_WAKE_CYC     (`LPC_WAKE_FILT_US * `LPC_CLK_MHZ)
`define LPC_CNT_W        10

`endif

// ---- pkg/lpc_pkg.sv ----
// types of the lin physical-layer control block
package lpc_pkg;

  typedef enum logic [1:0] {LPC_SLOPE_NORMAL, LPC_SLOPE_SLOW, LPC_SLOPE_FAST} lpc_slope_t;

  typedef enum logic {LPC_TX_ON, LPC_TX_OT_OFF} lpc_tx_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lpc_wb_req_t;

  typedef struct packed {
    logic       ot_ie;
    logic       tx_bit;
    logic       undervolt_shutdown_disable;
    logic       en;
    logic [1:0] sr;
  } lpc_ctrl_t;

  typedef struct packed {
    logic          ack;
    logic [31:0]   dat;
    lpc_ctrl_t     ctrl;
    lpc_slope_t    slope;
    lpc_tx_state_t tx_state;
    logic          ot;
    logic          irq;
    logic          uv_block;
    logic          rx;
    logic [9:0]    cnt;
    logic          wake_src;
    logic          wake_pulse;
    logic          drive_dom;
  } lpc_state_t;

endpackage : lpc_pkg

// ---- bench/lpc_bus_node.sv ----
// model of the other nodes sharing the single-wire bus
`timescale 1ns/1ps

module lpc_bus_node (
  // drivers of the wire
  input  wire logic i_dut_dominant,
  input  wire logic i_other_dominant,
  // sensed wire level
  output logic      o_bus_level
);
  // ------------------------------
  // wired-and line
  // ------------------------------
  // the pull-up sets the line recessive whenever no node pulls it low,
  // so a released line never keeps its last dominant value
  assign o_bus_level = ~(i_dut_dominant | i_other_dominant);
endmodule : lpc_bus_node

// ---- bench/tb_top.sv ----
// self-checking bench of the lin physical-layer control block
`timescale 1ns/1ps

module tb_top;
  import lpc_pkg::*;

  // ------------------------------
  // signals
  // ------------------------------
  typedef struct packed {
    logic [7:0] wr;
    logic       txd;
    logic [1:0] slope;
    logic       en;
    logic       dom;
  } lpc_row_t;

  logic        i_core_clk;
  logic        i_rst;
  lpc_wb_req_t wb_req;
  logic        o_wb_ack;
  logic [31:0] o_wb_dat;
  logic        txd;
  logic        bus_dom;
  lpc_slope_t  slope;
  logic        phy_en;
  logic        bus_level;
  logic        rxd;
  logic        overtemp;
  logic        undervolt;
  logic        low_power;
  logic        irq;
  logic        wake;
  logic        other_dom;
  logic [7:0]  rd;
  int          n_errors;
  int          check_count;
  int          wake_cnt;
  lpc_row_t    rows [6];

  lpc_phy DUT (
    .i_core_clk         (i_core_clk),
    .i_rst              (i_rst),
    .i_wb               (wb_req),
    .o_wb_ack           (o_wb_ack),
    .o_wb_dat           (o_wb_dat),
    .i_txd              (txd),
    .o_bus_dominant     (bus_dom),
    .o_slope            (slope),
    .o_phy_enable       (phy_en),
    .i_bus_rx           (bus_level),
    .o_rxd              (rxd),
    .i_overtemp         (overtemp),
    .i_supply_undervolt (undervolt),
    .i_low_power        (low_power),
    .o_irq              (irq),
    .o_wake_event       (wake)
  );

  lpc_bus_node u_node (
    .i_dut_dominant   (bus_dom),
    .i_other_dominant (other_dom),
    .o_bus_level      (bus_level)
  );

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic wrap_up();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : step

  // one classic cycle; held until ack is sampled high at an edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    rd = o_wb_dat[7:0];
    if (o_wb_ack !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    wb_req <= '0;
    @(posedge i_core_clk);
  endtask : wb

  // ------------------------------
  // clock, watchdog, wake monitor
  // ------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  initial begin
    step(100000);
    n_errors++;
    wrap_up();
  end

  always @(posedge i_core_clk) begin
    if (wake === 1'b1) wake_cnt++;
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    i_rst = 1'b1;
    wb_req = '0;
    txd = 1'b1;
    overtemp = 1'b0;
    undervolt = 1'b0;
    low_power = 1'b0;
    other_dom = 1'b0;
    n_errors = 0;
    check_count = 0;
    wake_cnt = 0;
    rows[0] = '{8'h04, 1'b1, 2'h0, 1'b1, 1'b0};
    rows[1] = '{8'h05, 1'b1, 2'h1, 1'b1, 1'b0};
    rows[2] = '{8'h06, 1'b0, 2'h2, 1'b1, 1'b1};
    rows[3] = '{8'h07, 1'b1, 2'h0, 1'b1, 1'b0};
    rows[4] = '{8'h14, 1'b1, 2'h0, 1'b1, 1'b1};
    rows[5] = '{8'h10, 1'b0, 2'h0, 1'b0, 1'b0};
    step(20);
    i_rst <= 1'b0;
    step(2);
    wb(1'b0, 8'h18, 8'h00);
    chk("reset reg", rd, 8'h20);
    chk("reset slope", {6'h0, slope}, 8'h00);
    chk("reset en", {7'h0, phy_en}, 8'h00);
    chk("reset rxd", {7'h0, rxd}, 8'h01);
    wb(1'b0, 8'h30, 8'h00);
    chk("unmapped", rd, 8'h00);
    foreach (rows[i]) begin
      txd <= rows[i].txd;
      wb(1'b1, 8'h18, rows[i].wr);
      step(3);
      chk("slope", {6'h0, slope}, {6'h0, rows[i].slope});
      chk("enable", {7'h0, phy_en}, {7'h0, rows[i].en});
      chk("dominant", {7'h0, bus_dom}, {7'h0, rows[i].dom});
      chk("rxd", {7'h0, rxd}, {7'h0, ~rows[i].dom});
      wb(1'b0, 8'h18, 8'h00);
      chk("readback", rd, rows[i].wr | (rows[i].dom ? 8'h00 : 8'h20));
    end
    // overtemperature: shutdown, interrupt, read clear, fresh onset
    txd <= 1'b1;
    wb(1'b1, 8'h18, 8'h94);
    overtemp <= 1'b1;
    step(3);
    chk("ot irq", {7'h0, irq}, 8'h01);
    chk("ot off", {7'h0, bus_dom}, 8'h00);
    wb(1'b0, 8'h18, 8'h00);
    chk("ot reg", rd, 8'hf4);
    step(3);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    txd <= 1'b0;
    overtemp <= 1'b0;
    step(3);
    chk("still off", {7'h0, bus_dom}, 8'h00);
    txd <= 1'b1;
    step(3);
    chk("re-enabled", {7'h0, bus_dom}, 8'h01);
    overtemp <= 1'b1;
    step(3);
    chk("fresh irq", {7'h0, irq}, 8'h01);
    overtemp <= 1'b0;
    wb(1'b0, 8'h18, 8'h00);
    // low power: driver off, long dominant then release wakes
    low_power <= 1'b1;
    step(3);
    chk("lp off", {7'h0, bus_dom}, 8'h00);
    other_dom <= 1'b1;
    step(500);
    other_dom <= 1'b0;
    step(5);
    chk("short pulse", wake_cnt[7:0], 8'h00);
    other_dom <= 1'b1;
    step(1100);
    other_dom <= 1'b0;
    step(5);
    chk("wake pulse", wake_cnt[7:0], 8'h01);
    wb(1'b0, 8'h1c, 8'h00);
    chk("wake flag", rd, 8'h01);
    wb(1'b1, 8'h1c, 8'h01);
    wb(1'b0, 8'h1c, 8'h00);
    chk("wake clear", rd, 8'h00);
    low_power <= 1'b0;
    // undervoltage with shutdown active, then disabled
    wb(1'b1, 8'h18, 8'h04);
    txd <= 1'b0;
    step(3);
    undervolt <= 1'b1;
    step(3);
    chk("uv waits", {7'h0, bus_dom}, 8'h01);
    txd <= 1'b1;
    step(3);
    txd <= 1'b0;
    step(3);
    chk("uv held", {7'h0, bus_dom}, 8'h00);
    undervolt <= 1'b0;
    step(3);
    chk("uv gone dom", {7'h0, bus_dom}, 8'h00);
    txd <= 1'b1;
    step(3);
    txd <= 1'b0;
    step(3);
    chk("uv resumed", {7'h0, bus_dom}, 8'h01);
    wb(1'b1, 8'h18, 8'h0c);
    txd <= 1'b1;
    undervolt <= 1'b1;
    step(3);
    txd <= 1'b0;
    step(3);
    chk("undervolt_shutdown_disable on", {7'h0, bus_dom}, 8'h01);
    // mid-run reset: control bits and driver back to their reset state
    i_rst <= 1'b1;
    step(3);
    i_rst <= 1'b0;
    step(2);
    chk("rerun en", {7'h0, phy_en}, 8'h00);
    chk("rerun dom", {7'h0, bus_dom}, 8'h00);
    chk("rerun slope", {6'h0, slope}, 8'h00);
    chk("rerun rxd", {7'h0, rxd}, 8'h01);
    wb(1'b0, 8'h18, 8'h00);
    chk("rerun reg", rd, 8'h20);
    wrap_up();
  end
endmodule : tb_top
